// *** rtl/ssf_pkg.sv ***
// Constants and carriers for the serial port status block.
// Assumes one AXI4-Lite slave on aclk and a link clock from the port logic.
//
// Notes on behaviour
// (R1) The receive buffer element count reads in bits 28-24 and means something only with the enhanced buffer on.
// (R2) The transmit buffer element count reads in bits 20-16 and means something only with the enhanced buffer on.
// (R3) Hardware sets the frame error flag at bit 12 on a frame error and software clears it; it matters only in framed mode.
// (R4) The activity flag at bit 11 is high while the port handles any transaction and low when idle.
// (R5) The transmit underrun flag at bit 8 is set when the transmit buffer underruns; it matters only in framed mode.
// (R6) Underrun is removed only by disabling and then re-enabling the module, by no other means; here writing the on bit to zero clears it at once.
// (R7) Bit 7 is one when the shift register is empty and zero while it holds data, valid with the enhanced buffer on.
// (R8) A word completed while the previous one is still unread is discarded and the overflow flag at bit 6 is set.
// (R9) Only hardware sets the overflow flag, only a written zero clears it, and a written one does nothing.
// (R10) The receive FIFO empty flag at bit 5 is one when the read pointer equals the write pointer.
// (R11) All unimplemented status bits read zero and ignore writes.
// (R12) Transmit empty (bit 3, reset one), transmit full (bit 1) and receive full (bit 0) track occupancy each cycle;
// transmit empty and full here come from the level snapshot and may lag by up to one round trip.
package ssf_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [3:0] SSF_STATUS_ADDR  = 4'h0;
   localparam logic [3:0] SSF_CONTROL_ADDR = 4'h4;
   localparam logic [3:0] SSF_DEPTH_ADDR   = 4'h8;

   // Status field positions
   localparam int SSF_RXCNT_LSB = 24;
   localparam int SSF_TXCNT_LSB = 16;
   localparam int SSF_FRAME_ERROR_FLAG    = 12;
   localparam int SSF_BUSY      = 11;
   localparam int SSF_TUR       = 8;
   localparam int SSF_SHIFTER_EMPTY_FLAG      = 7;
   localparam int SSF_ROV       = 6;
   localparam int SSF_RBE       = 5;
   localparam int SSF_TBE       = 3;
   localparam int SSF_TBF       = 1;
   localparam int SSF_RBF       = 0;

   // Control field positions
   localparam int SSF_CTL_ON    = 0;
   localparam int SSF_CTL_ENH   = 1;
   localparam int SSF_CTL_FRM   = 2;
   localparam int SSF_CTL_RDBUF = 3;
   localparam logic [2:0] SSF_CONTROL_RESET = 3'h0;

   // Documented buffer depth
   localparam int SSF_DEPTH = 16;

   // AXI responses
   localparam logic [1:0] SSF_RESP_OKAY   = 2'h0;
   localparam logic [1:0] SSF_RESP_SLVERR = 2'h2;

   // Link-side status carried to the bus domain
   typedef struct packed {
      logic [4:0] rx_count;
      logic [4:0] tx_count;
      logic       busy;
      logic       shifter_empty;
      logic       rx_fifo_empty;
   } ssf_link_type;

   // Link events, each a toggle
   typedef struct packed {
      logic frame_error;
      logic underrun;
      logic word_done;
   } ssf_event_type;

endpackage : ssf_pkg

// *** rtl/ssf_sync.sv ***
// Two-flop synchroniser for a vector of independent levels or toggles.
// Assumes each bit changes at most once per a few destination clocks.
`timescale 1ns/100ps
module ssf_sync
#(
   parameter int WIDTH = 1
)
(
   // Destination clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Data
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } ssf_sync_state_type;

   ssf_sync_state_type s_q;
   ssf_sync_state_type s_d;

   initial
   begin
      if (WIDTH < 1) $error("ssf_sync: WIDTH must be at least 1");
   end

   // First stage feeds only the second
   always_comb
   begin
      s_d.meta = din;
      s_d.sync = s_q.meta;
   end

   // Synchronous reset to zero
   always_ff @(posedge clk)
   begin
      if (!rst_n) s_q <= '0;
      else        s_q <= s_d;
   end

   assign dout = s_q.sync;
endmodule // ssf_sync

// *** rtl/ssf_status.sv ***
// Status register of a serial port with an AXI4-Lite slave.
// Assumes the port's shifter runs on link_clk and reports levels and
// event pulses; its own reset is link_rst_n, synchronous, active low.
`timescale 1ns/100ps
module ssf_status
   import ssf_pkg::*;
#(
   parameter int DEPTH = ssf_pkg::SSF_DEPTH
)
(
   // Bus clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Link clock and reset
   input  wire logic        link_clk,
   input  wire logic        link_rst_n,
   // Link-side port signals
   input  wire logic        link_busy,
   input  wire logic        link_shifter_empty,
   input  wire logic        link_frame_error,
   input  wire logic        link_underrun,
   input  wire logic        link_word_done,
   input  wire logic        link_tx_pop,
   input  wire logic        link_tx_push,
   input  wire logic [4:0]  current_read_pointer,
   input  wire logic [4:0]  software_write_pointer,
   // AXI4-Lite write address
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Control outputs to the port logic
   output logic             port_on,
   output logic             enhanced_buffer_enable,
   output logic             framed_mode_enable
);
   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   initial
   begin
      if (DEPTH < 1 || DEPTH > 31) $error("ssf_status: DEPTH 1..31");
   end

   // ----------------------------------------------------------------
   // Link domain
   // ----------------------------------------------------------------
   typedef struct packed {
      ssf_link_type  lvl;
      ssf_link_type  snap;
      logic          req;
      ssf_event_type tog;
      logic [4:0]    tx_count;
   } ssf_lstate_type;

   ssf_lstate_type l_q;
   ssf_lstate_type l_d;

   // Toggles of the snapshot handshake, each behind two flops
   logic          req_s;
   logic          ack_s;

   // Register levels, turn events into toggles, track tx occupancy
   always_comb
   begin
      l_d = l_q;
      l_d.lvl.busy          = link_busy;
      l_d.lvl.shifter_empty = link_shifter_empty;
      // (R10) Empty on pointer match
      l_d.lvl.rx_fifo_empty = (current_read_pointer == software_write_pointer);
      // (R1) Receive occupancy from pointers
      l_d.lvl.rx_count = software_write_pointer - current_read_pointer;
      // (R2) Transmit occupancy, saturating at the buffer depth
      if (link_tx_push && !link_tx_pop && l_q.tx_count < 5'(DEPTH))
         l_d.tx_count = l_q.tx_count + 5'h01;
      else if (link_tx_pop && !link_tx_push && l_q.tx_count != 5'h00)
         l_d.tx_count = l_q.tx_count - 5'h01;
      l_d.lvl.tx_count = l_d.tx_count;
      // Offer a fresh snapshot only once the last one is acknowledged,
      // so the bus side never samples the word while it moves
      if (ack_s == l_q.req)
      begin
         l_d.snap = l_q.lvl;
         l_d.req  = ~l_q.req;
      end
      // Each event pulse flips its toggle
      l_d.tog.frame_error = l_q.tog.frame_error ^ link_frame_error;
      l_d.tog.underrun    = l_q.tog.underrun ^ link_underrun;
      l_d.tog.word_done   = l_q.tog.word_done ^ link_word_done;
   end

   always_ff @(posedge link_clk)
   begin
      if (!link_rst_n) l_q <= '0;
      else             l_q <= l_d;
   end

   // ----------------------------------------------------------------
   // Crossing into the bus domain
   // ----------------------------------------------------------------
   // Levels cross as one held snapshot under a toggle request and a
   // toggle acknowledge. Only the request and acknowledge bits pass
   // through flops; the snapshot stands still from its request until
   // the acknowledge returns, so no count or pointer difference can
   // tear. The price is age: a status read may show levels up to about
   // one round trip, some ten bus clocks, old.
   // Events cross as toggles, one bit each, and are never lost while
   // each event type keeps a few link clocks of spacing.
   ssf_link_type  lvl_s;
   ssf_event_type tog_s;

   // Snapshot request into the bus domain
   ssf_sync #(.WIDTH(1)) u_req_sync
   (
      .clk   (aclk),
      .rst_n (aresetn),
      .din   (l_q.req),
      .dout  (req_s)
   );

   // Event toggles into the bus domain
   ssf_sync #(.WIDTH($bits(ssf_event_type))) u_tog_sync
   (
      .clk   (aclk),
      .rst_n (aresetn),
      .din   (l_q.tog),
      .dout  (tog_s)
   );

   // ----------------------------------------------------------------
   // Bus domain state
   // ----------------------------------------------------------------
   typedef struct packed {
      ssf_event_type tog_seen;
      ssf_link_type  lvl;
      logic          ack;
      logic          frame_error;
      logic          underrun;
      logic          overflow;
      logic          rx_held;
      logic [2:0]    control;
      logic          aw_got;
      logic [3:0]    aw_addr;
      logic          w_got;
      logic [31:0]   w_data;
      logic [3:0]    w_strb;
      logic          bvalid;
      logic [1:0]    bresp;
      logic          rvalid;
      logic [31:0]   rdata;
      logic [1:0]    rresp;
   } ssf_bstate_type;

   ssf_bstate_type b_q;
   ssf_bstate_type b_d;

   // Acknowledge toggle back into the link domain
   ssf_sync #(.WIDTH(1)) u_ack_sync
   (
      .clk   (link_clk),
      .rst_n (link_rst_n),
      .din   (b_q.ack),
      .dout  (ack_s)
   );

   // Levels as last captured from the link side
   assign lvl_s = b_q.lvl;

   // Decode used by both channels
   function automatic logic ssf_mapped(input logic [3:0] a);
      ssf_mapped = (a == SSF_STATUS_ADDR) || (a == SSF_CONTROL_ADDR)
                || (a == SSF_DEPTH_ADDR);
   endfunction

   logic [31:0]   status_word;
   ssf_event_type ev;
   logic          wr_fire;
   logic          rd_fire;
   logic          st_lo_wr;
   logic          ctl_wr;
   logic [2:0]    ctl_new;
   logic          st_hi_wr;
   logic          rd_strobe;

   // Assemble the status word
   always_comb
   begin
      // (R11) Unused bits stay zero
      status_word = 32'h0000_0000;
      // (R1) Receive element count
      status_word[SSF_RXCNT_LSB +: 5] = lvl_s.rx_count;
      // (R2) Transmit element count
      status_word[SSF_TXCNT_LSB +: 5] = lvl_s.tx_count;
      // (R3) Frame error as latched
      status_word[SSF_FRAME_ERROR_FLAG] = b_q.frame_error;
      // (R4) Activity follows the port
      status_word[SSF_BUSY]   = lvl_s.busy;
      // (R5) Underrun as latched
      status_word[SSF_TUR]    = b_q.underrun;
      // (R7) Shift register empty
      status_word[SSF_SHIFTER_EMPTY_FLAG]   = lvl_s.shifter_empty;
      // (R8) Overflow as latched
      status_word[SSF_ROV]    = b_q.overflow;
      // (R10) Receive FIFO empty
      status_word[SSF_RBE]    = lvl_s.rx_fifo_empty;
      // (R12) Occupancy flags
      status_word[SSF_TBE]    = (lvl_s.tx_count == 5'h00);
      status_word[SSF_TBF]    = (lvl_s.tx_count == 5'(DEPTH));
      status_word[SSF_RBF]    = b_q.rx_held;
   end

   // Next state of bus domain
   always_comb
   begin
      b_d = b_q;
      ev  = tog_s ^ b_q.tog_seen;
      b_d.tog_seen = tog_s;
      // Take the snapshot once its request has crossed
      if (req_s != b_q.ack)
      begin
         b_d.lvl = l_q.snap;
         b_d.ack = req_s;
      end

      // Capture address and data in either order
      if (s_axi_awvalid && !b_q.aw_got)
      begin
         b_d.aw_got  = 1'b1;
         b_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !b_q.w_got)
      begin
         b_d.w_got  = 1'b1;
         b_d.w_data = s_axi_wdata;
         b_d.w_strb = s_axi_wstrb;
      end
      wr_fire  = b_q.aw_got && b_q.w_got && !b_q.bvalid;
      st_lo_wr = wr_fire && b_q.aw_addr == SSF_STATUS_ADDR && b_q.w_strb[0];
      st_hi_wr = wr_fire && b_q.aw_addr == SSF_STATUS_ADDR && b_q.w_strb[1];
      ctl_wr   = wr_fire && b_q.aw_addr == SSF_CONTROL_ADDR && b_q.w_strb[0];
      ctl_new  = ctl_wr ? b_q.w_data[2:0] : b_q.control;
      if (wr_fire)
      begin
         b_d.aw_got = 1'b0;
         b_d.w_got  = 1'b0;
         b_d.bvalid = 1'b1;
         b_d.bresp  = ssf_mapped(b_q.aw_addr) ? SSF_RESP_OKAY
                                               : SSF_RESP_SLVERR;
         // Read strobe bit lies above the stored field, so never sticks
         b_d.control = ctl_new;
      end
      if (b_q.bvalid && s_axi_bready) b_d.bvalid = 1'b0;

      // Software drains the held word with the read strobe bit
      rd_strobe = ctl_wr && b_q.w_data[SSF_CTL_RDBUF];
      if (rd_strobe) b_d.rx_held = 1'b0;
      // (R8) Word arriving onto an unread one is dropped, overflow set;
      // a drain in the same cycle frees the holder for the new word
      if (ev.word_done)
      begin
         if (b_q.rx_held && !rd_strobe) b_d.overflow = 1'b1;
         else                           b_d.rx_held  = 1'b1;
      end
      // (R9) Only a written zero clears; set wins over clear
      if (st_lo_wr && !b_q.w_data[SSF_ROV]
          && !(ev.word_done && b_q.rx_held && !rd_strobe))
         b_d.overflow = 1'b0;
      // (R3) Frame error cleared by a zero on byte lane one; the set
      // below comes later, so hardware wins a tie
      if (st_hi_wr && !b_q.w_data[SSF_FRAME_ERROR_FLAG])
         b_d.frame_error = 1'b0;
      if (ev.frame_error && b_q.control[SSF_CTL_FRM])
         b_d.frame_error = 1'b1;

      // (R6) Underrun leaves only when the module is switched off
      if (!ctl_new[SSF_CTL_ON]) b_d.underrun = 1'b0;
      // (R5) Underrun set in framed mode
      if (ev.underrun && b_q.control[SSF_CTL_FRM]
          && b_q.control[SSF_CTL_ON])
         b_d.underrun = 1'b1;

      // Read channel
      rd_fire = s_axi_arvalid && !b_q.rvalid;
      if (rd_fire)
      begin
         b_d.rvalid = 1'b1;
         b_d.rresp  = ssf_mapped(s_axi_araddr) ? SSF_RESP_OKAY
                                                : SSF_RESP_SLVERR;
         case (s_axi_araddr)
            SSF_STATUS_ADDR:  b_d.rdata = status_word;
            SSF_CONTROL_ADDR: b_d.rdata = {29'h0, b_q.control};
            SSF_DEPTH_ADDR:   b_d.rdata = 32'(DEPTH);
            default:          b_d.rdata = 32'h0000_0000;
         endcase
      end
      if (b_q.rvalid && s_axi_rready) b_d.rvalid = 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         b_q         <= '0;
         b_q.control <= SSF_CONTROL_RESET;
      end
      else
         b_q <= b_d;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign s_axi_awready = !b_q.aw_got;
   assign s_axi_wready  = !b_q.w_got;
   assign s_axi_bvalid  = b_q.bvalid;
   assign s_axi_bresp   = b_q.bresp;
   assign s_axi_arready = !b_q.rvalid;
   assign s_axi_rvalid  = b_q.rvalid;
   assign s_axi_rdata   = b_q.rdata;
   assign s_axi_rresp   = b_q.rresp;

   // Control levels; port logic synchronises them on its side
   assign port_on                = b_q.control[SSF_CTL_ON];
   assign enhanced_buffer_enable = b_q.control[SSF_CTL_ENH];
   assign framed_mode_enable     = b_q.control[SSF_CTL_FRM];
endmodule // ssf_status

// *** sim/ssf_status_props.sv ***
// Bus-side checks of the serial port status block.
// Assumes a bind onto ssf_status; watches its ports only.
`timescale 1ns/100ps
module ssf_status_props
   import ssf_pkg::*;
#(
   parameter int DEPTH = 16
)
(
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Write handshakes
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   // Read channels
   input wire logic [3:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   import ssf_pkg::*;
   logic [3:0] ra_q;
   logic       bad;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Address of the read under way, kept for checking its answer
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ra_q <= 4'h0;
      else if (s_axi_arvalid && s_axi_arready)
         ra_q <= s_axi_araddr;
   end
   assign bad = !(ra_q inside {SSF_STATUS_ADDR, SSF_CONTROL_ADDR,
                               SSF_DEPTH_ADDR});
   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read data dropped");
   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   a_bhold: assert property (p_bhold) else $error("write answer dropped");
   property p_arblock;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_arblock: assert property (p_arblock) else $error("read taken early");
   property p_rlat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rlat: assert property (p_rlat) else $error("read answer late");
   property p_wlat;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |-> ##2 s_axi_bvalid;
   endproperty
   a_wlat: assert property (p_wlat) else $error("write answer late");
   property p_slverr;
      s_axi_rvalid && bad |-> s_axi_rresp == SSF_RESP_SLVERR
                              && s_axi_rdata == 32'h0;
   endproperty
   a_slverr: assert property (p_slverr) else $error("unmapped read");
   property p_okay;
      s_axi_rvalid && !bad |-> s_axi_rresp == SSF_RESP_OKAY;
   endproperty
   a_okay: assert property (p_okay) else $error("mapped read refused");
   property p_rsv;
      s_axi_rvalid && ra_q == SSF_STATUS_ADDR
         |-> (s_axi_rdata & 32'hE0E0E614) == 32'h0;
   endproperty
   a_rsv: assert property (p_rsv) else $error("spare status bit set");
   property p_depth;
      s_axi_rvalid && ra_q == SSF_DEPTH_ADDR |-> s_axi_rdata == DEPTH;
   endproperty
   a_depth: assert property (p_depth) else $error("depth wrong");
   c_stat: cover property (s_axi_rvalid && ra_q == SSF_STATUS_ADDR);
   c_bad: cover property (s_axi_rvalid && bad);
   c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule // ssf_status_props
bind ssf_status ssf_status_props #(.DEPTH(DEPTH)) u_props (.*);

// *** sim/ssf_link_model.sv ***
// Far-side model of the port's shifter and buffers, on the link clock.
// Assumes the bench flips one request bit per event, spaced out.
`timescale 1ns/100ps
module ssf_link_model
(
   // Link clock and reset
   input  wire logic        link_clk,
   input  wire logic        link_rst_n,
   // Requests from the bench
   input  wire logic [4:0]  ev_tgl,
   input  wire logic [11:0] lvl,
   // Port signals into the block
   output logic             link_frame_error,
   output logic             link_underrun,
   output logic             link_word_done,
   output logic             link_tx_push,
   output logic             link_tx_pop,
   output logic             link_busy,
   output logic             link_shifter_empty,
   output logic [4:0]       current_read_pointer,
   output logic [4:0]       software_write_pointer
);
   logic [4:0] tgl_q;
   always_ff @(posedge link_clk)
   begin
      tgl_q <= ev_tgl;
      {link_frame_error, link_underrun, link_word_done, link_tx_push,
       link_tx_pop} <= link_rst_n ? ev_tgl ^ tgl_q : 5'h0;
   end
   // levels launched from the link clock
   always_ff @(posedge link_clk)
   begin
      {link_busy, link_shifter_empty, current_read_pointer,
       software_write_pointer} <= lvl;
   end
endmodule // ssf_link_model

// *** sim/tb.sv ***
// Self-checking bench of the serial port status block.
// Assumes the far side is ssf_link_model on a free 64 ns link clock.
`timescale 1ns/100ps
module tb;
   import ssf_pkg::*;
   localparam int DP = 16;
   logic aclk, aresetn, link_clk, link_rst_n;
   logic link_busy, link_shifter_empty, link_frame_error, link_underrun;
   logic link_word_done, link_tx_pop, link_tx_push;
   logic [4:0] current_read_pointer, software_write_pointer, ev_tgl, txc;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, fe, tur, rov, rbf;
   logic port_on, enhanced_buffer_enable, framed_mode_enable;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [11:0] lvl;
   int fails, cmp_count, n;
   ssf_status #(.DEPTH(DP)) dut (.*);
   ssf_link_model u_link (.*);
   // Clocks of unrelated phase
   initial
   begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   initial
   begin
      link_clk = 1'b0;
      #7;
      forever #32 link_clk = ~link_clk;
   end
   // Expected status word from the far side's state
   function automatic logic [31:0] exp_st();
      return {3'h0, lvl[4:0] - lvl[9:5], 3'h0, txc, 3'h0, fe, lvl[11],
              2'h0, tur, lvl[10], rov, lvl[9:5] == lvl[4:0], 1'b0,
              txc == 5'h0, 1'b0, txc == 5'h10, rbf};
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic give_verdict();
      $display("compared %0d, mismatched %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Bus master: payload held until each channel is taken
   task automatic wr(input logic [3:0] a, input logic [31:0] v,
                     input logic [3:0] s);
      logic ta;
      logic tw;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      @(negedge aclk);
      while (s_axi_awvalid || s_axi_wvalid)
      begin
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         @(posedge aclk);
         if (ta)
            s_axi_awvalid <= 1'b0;
         if (tw)
            s_axi_wvalid <= 1'b0;
         @(negedge aclk);
      end
      while (!s_axi_bvalid)
         @(negedge aclk);
      r = s_axi_bresp;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(negedge aclk);
      while (!s_axi_arready)
         @(negedge aclk);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      @(negedge aclk);
      while (!s_axi_rvalid)
         @(negedge aclk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask
   // Status read after the crossing has settled
   task automatic st();
      repeat (30) @(posedge aclk);
      rd(SSF_STATUS_ADDR);
      chk("status", exp_st(), d);
   endtask
   task automatic ev(input int i);
      @(posedge aclk);
      ev_tgl[i] <= ~ev_tgl[i];
      repeat (6) @(posedge link_clk);
   endtask
   // Watchdog far beyond the expected run
   initial
   begin
      #500000;
      fails++;
      give_verdict();
   end
   initial
   begin
      {aresetn, link_rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 0;
      {s_axi_wdata, s_axi_wstrb, ev_tgl, txc, fe, tur, rov, rbf} = 0;
      lvl = 12'h400;
      void'($urandom(32'h47a0));
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      link_rst_n <= 1'b1;
      st();
      rd(SSF_DEPTH_ADDR);
      chk("depth", DP, d);
      wr(4'hC, 32'hFFFFFFFF, 4'hF);
      chk("wr refused", 32'(SSF_RESP_SLVERR), 32'(r));
      rd(4'hC);
      chk("rd refused", {30'h0, SSF_RESP_SLVERR}, {d[29:0], r});
      wr(SSF_STATUS_ADDR, 32'hFFFFFFFF, 4'hF);
      st();
      wr(SSF_CONTROL_ADDR, 32'h7, 4'hF);
      chk("ctrl", 32'h7, {29'h0, framed_mode_enable,
          enhanced_buffer_enable, port_on});
      rd(SSF_CONTROL_ADDR);
      chk("ctrl rd", 32'h7, d);
      $display("test registers done");
      for (int k = 0; k < 5; k++)
      begin
         @(posedge aclk);
         lvl[9:0] <= (k == 4) ? 10'h3E0 : 10'($urandom);
         st();
      end
      for (int k = 0; k < 4; k++)
      begin
         @(posedge aclk);
         lvl[11:10] <= 2'(k);
         st();
      end
      $display("test levels done");
      n = $urandom_range(15, 1);
      for (int k = 0; k < DP; k++)
      begin
         ev(1);
         txc = txc + 5'h1;
         if (k + 1 == n || k + 1 == DP)
            st();
      end
      repeat (DP) ev(0);
      txc = 5'h0;
      st();
      $display("test transmit count done");
      ev(2);
      rbf = 1'b1;
      st();
      ev(2);
      rov = 1'b1;
      st();
      wr(SSF_STATUS_ADDR, 32'h40, 4'hF);
      st();
      wr(SSF_STATUS_ADDR, 32'h0, 4'h1);
      rov = 1'b0;
      wr(SSF_CONTROL_ADDR, 32'hF, 4'hF);
      rbf = 1'b0;
      rd(SSF_CONTROL_ADDR);
      chk("ctrl strobe", 32'h7, d);
      st();
      $display("test overflow done");
      wr(SSF_CONTROL_ADDR, 32'h3, 4'hF);
      ev(4);
      st();
      wr(SSF_CONTROL_ADDR, 32'h7, 4'hF);
      ev(4);
      fe = 1'b1;
      st();
      wr(SSF_STATUS_ADDR, 32'h0, 4'h2);
      fe = 1'b0;
      ev(3);
      tur = 1'b1;
      st();
      wr(SSF_STATUS_ADDR, 32'h0, 4'hF);
      st();
      wr(SSF_CONTROL_ADDR, 32'h6, 4'hF);
      tur = 1'b0;
      wr(SSF_CONTROL_ADDR, 32'h7, 4'hF);
      st();
      $display("test frame and underrun done");
      give_verdict();
   end
endmodule // tb
